// [inc/adc_out_pkg.sv]
// shared constants, states and carriers for the converter result output port
package adc_out_pkg;

   ////////////////////////////////////////////////////////////////////////////
   // sizes and counts
   localparam int RESULT_BITS = 16;
   localparam int STEP_BITS = 5;
   // rising edges t0..t16, one falling edge after each
   localparam logic [4:0] CLOCK_EDGES = 5'h11;
   localparam logic [4:0] FIRST_STEP = 5'h00;

   ////////////////////////////////////////////////////////////////////////////
   // timing
   localparam int SYS_CLK_PERIOD_NS = 8;
   localparam int LINK_CLK_PERIOD_NS = 125;
   localparam int PARALLEL_SETUP_NS = 20;
   localparam int SERIAL_SETTLE_NS = 120;
   // parallel word settles one link period before status falls
   localparam int PARALLEL_LEAD_NS = LINK_CLK_PERIOD_NS;
   // serial bit settles at the rising edge, half a bit period before sampling
   localparam int SERIAL_LEAD_NS = LINK_CLK_PERIOD_NS;

   ////////////////////////////////////////////////////////////////////////////
   // reset values
   localparam logic [15:0] CODE_RESET = 16'hFFFF;
   localparam logic [15:0] PINS_IDLE_N = 16'hFFFF;
   localparam logic [15:0] VALUE_RESET = 16'h0000;
   localparam logic INVALID_BIT = 1'h0;

   ////////////////////////////////////////////////////////////////////////////
   // types
   typedef enum logic [0:0] {
      LINK_IDLE = 1'b0,
      LINK_RUN = 1'b1
   } link_mode_type;

   typedef struct packed {
      logic clock;
      logic status;
      logic serial_n;
      logic [RESULT_BITS-1:0] parallel_n;
   } result_pins_type;

   typedef struct packed {
      logic meta;
      logic sync;
   } sync_state_type;

   typedef struct packed {
      logic start_seen;
      logic start_toggle;
      logic [RESULT_BITS-1:0] value;
   } sys_state_type;

   typedef struct packed {
      link_mode_type mode;
      logic start_seen;
      logic [STEP_BITS-1:0] step;
      logic [RESULT_BITS-1:0] code;
      result_pins_type pins;
   } link_state_type;

endpackage : adc_out_pkg

// [sim/adc_result_output_port_assertions.sv]
// concurrent checks on the result pins of the converter output port
`timescale 1ns/1ns
`default_nettype none

module adc_result_output_port_checker
   import adc_out_pkg::*;
(
   // clocks and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   input wire logic link_clk_in,
   // conversion request
   input wire logic convert_start_in,
   input wire logic [RESULT_BITS-1:0] conversion_value_in,
   // result
   input wire result_pins_type result_pins_out,
   input wire logic conv_busy_out
);
   result_pins_type p;
   assign p = result_pins_out;
   // first tick after reset would compare against unknown history
   logic armed_q;

   always_ff @(posedge link_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         armed_q <= 1'b0;
      end
      else
      begin
         armed_q <= 1'b1;
      end
   end
   // all pin logic lives on the link clock
   default clocking @(posedge link_clk_in); endclocking
   default disable iff (reset_in);

   ////////////////////////////////////////////////////////////////////////////
   property p_idle_low; !p.status |-> !p.clock; endproperty
   a_idle_low: assert property (p_idle_low) else $error("clock high while idle");
   property p_busy_len; $rose(p.status) |-> ##34 $fell(p.status); endproperty
   a_busy_len: assert property (p_busy_len) else $error("status length wrong");
   property p_toggle; p.status |=> p.clock != $past(p.clock); endproperty
   a_toggle: assert property (p_toggle) else $error("clock did not toggle");
   property p_ser_edge; armed_q && $changed(p.serial_n) |-> $rose(p.clock); endproperty
   a_ser_edge: assert property (p_ser_edge) else $error("serial moved off edge");
   property p_par_edge; armed_q && $changed(p.parallel_n) |-> $rose(p.clock); endproperty
   a_par_edge: assert property (p_par_edge) else $error("parallel moved off edge");
   property p_hold; !p.status |=> $stable(p.parallel_n) && $stable(p.serial_n); endproperty
   a_hold: assert property (p_hold) else $error("result not held");
   property p_setup; armed_q && $fell(p.status) |-> $stable(p.parallel_n); endproperty
   a_setup: assert property (p_setup) else $error("word moved at status fall");
   property p_first; $rose(p.status) |=> p.clock && p.serial_n && p.parallel_n == 16'h8000;
   endproperty
   a_first: assert property (p_first) else $error("bad first clock cycle");
endmodule : adc_result_output_port_checker

bind adc_result_output_port adc_result_output_port_checker chk (
   .sys_clk_in(sys_clk_in), .reset_in(reset_in), .link_clk_in(link_clk_in),
   .convert_start_in(convert_start_in), .conversion_value_in(conversion_value_in),
   .result_pins_out(result_pins_out), .conv_busy_out(conv_busy_out));

`default_nettype wire

// [sim/result_receiver.sv]
// receiving logic model: serial shift register and parallel latch
`timescale 1ns/1ns
`default_nettype none

module result_receiver
   import adc_out_pkg::*;
(
   // converter pins
   input wire result_pins_type pins_in,
   // captured data
   output logic [RESULT_BITS:0] shift_out,
   output logic [RESULT_BITS-1:0] word_out,
   output logic [4:0] falls_out,
   output logic [RESULT_BITS-1:0] inverted_twos_code_out
);
   // pin levels are the inverted code; flipping all bits below the top gives the two's form
   assign inverted_twos_code_out = {word_out[RESULT_BITS-1], ~word_out[RESULT_BITS-2:0]};
   initial falls_out = 5'h00;
   // 17 stages: the invalid first bit reaches the top on the last fall
   always @(negedge pins_in.clock)
   begin
      shift_out <= {shift_out[RESULT_BITS-1:0], pins_in.serial_n};
      falls_out <= falls_out + 5'h01;
   end
   always @(negedge pins_in.status)
      word_out <= pins_in.parallel_n;
endmodule : result_receiver

`default_nettype wire

// [sim/testbench.sv]
// self-checking bench for the converter result output port
`timescale 1ns/1ns
`default_nettype none
`define CHK(g, e, m) begin num_checks++; if ((g) !== (e)) begin mismatches++; \
   $display("MISMATCH at %0t: %s", $time, m); end end

module testbench;
   import adc_out_pkg::*;
   logic sys_clk_in = 1'b0, link_clk_in = 1'b0, reset_in = 1'b0, convert_start_in = 1'b0;
   logic [15:0] conversion_value_in = 16'h0000;
   result_pins_type pins;
   logic conv_busy_out;
   logic [16:0] shift;
   logic [15:0] word;
   logic [15:0] twos;
   logic [4:0] falls, falls0;
   int mismatches = 0, num_checks = 0, cycles = 0;
   logic [15:0] exp_q[$];

   adc_result_output_port uut (.sys_clk_in(sys_clk_in), .reset_in(reset_in),
      .link_clk_in(link_clk_in), .convert_start_in(convert_start_in),
      .conversion_value_in(conversion_value_in), .result_pins_out(pins),
      .conv_busy_out(conv_busy_out));
   result_receiver rx (.pins_in(pins), .shift_out(shift), .word_out(word), .falls_out(falls),
      .inverted_twos_code_out(twos));

   initial forever #4 sys_clk_in = ~sys_clk_in;
   // odd offset keeps the link clock out of phase with the system clock
   initial
   begin
      #3;
      forever
      begin
         #62 link_clk_in = ~link_clk_in;
         #63 link_clk_in = ~link_clk_in;
      end
   end

   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", num_checks, mismatches);
      if (mismatches == 0 && num_checks > 0)
         $display("Simulation passed");
      else
         $display("Simulation failed");
      $finish;
   endtask : tally_and_finish

   always @(posedge sys_clk_in)
   begin
      cycles++;
      if (cycles == 20000)
      begin
         mismatches++;
         tally_and_finish();
      end
   end

   task automatic pulse(input logic [15:0] v);
      @(posedge sys_clk_in);
      #1 conversion_value_in = v;
      convert_start_in = 1'b1;
      repeat (8) @(posedge sys_clk_in);
      #1 convert_start_in = 1'b0;
   endtask : pulse

   // a second start while busy must leave the running conversion alone
   task automatic convert(input logic [15:0] v, input bit poke);
      int n;
      n = 0;
      exp_q.push_back(v); // double inversion: pin level equals value bit
      falls0 = falls;
      pulse(v);
      while (pins.status !== 1'b1 && n < 200)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      #1 conversion_value_in = 16'($urandom);
      // busy level lags status by its two-flop crossing
      repeat (4) @(posedge sys_clk_in);
      #1;
      `CHK(conv_busy_out, 1'b1, "busy during conversion")
      if (poke)
         pulse(~v);
      while (pins.status === 1'b1 && n < 2000)
      begin
         @(posedge sys_clk_in);
         n++;
      end
      repeat (100) @(posedge sys_clk_in);
      v = exp_q.pop_front();
      `CHK(word, v, "parallel word at status fall")
      `CHK(shift[15:0], v, "serial word in receiver")
      `CHK(5'(falls - falls0), CLOCK_EDGES, "falling clock edges")
      `CHK(pins.parallel_n, v, "held parallel word")
      `CHK(pins.clock, 1'b0, "idle clock")
      `CHK(conv_busy_out, 1'b0, "busy after conversion")
      $display("test done value %h poke %0d", v, poke);
   endtask : convert

   initial
   begin
      static logic [15:0] tv[3] = '{16'hFFFF, 16'h8000, 16'h0001};
      static logic [15:0] tc[3] = '{16'h0000, 16'h7FFF, 16'hFFFE};
      static logic [15:0] tt[3] = '{16'h8000, 16'hFFFF, 16'h7FFE};
      void'($urandom(32'heeb4eb62));
      // a real edge on reset clears the link flops before their clock first ticks
      #1 reset_in = 1'b1;
      repeat (8) @(posedge sys_clk_in);
      #1 reset_in = 1'b0;
      `CHK(pins.parallel_n, PINS_IDLE_N, "reset pins")
      `CHK(pins.clock, 1'b0, "reset clock")
      repeat (4) @(posedge sys_clk_in);
      for (int i = 0; i < 3; i++)
      begin
         convert(tv[i], 1'b0);
         `CHK(~word, tc[i], "scale code")
         `CHK(twos, tt[i], "inverted twos code")
      end
      for (int i = 0; i < 4; i++)
         convert(16'($urandom), i < 2);
      tally_and_finish();
   end
endmodule : testbench

`default_nettype wire

// [verilog/adc_result_output_port.sv]
// parallel and serial result output port of a 16-bit converter
`timescale 1ns/1ns
`default_nettype none

module adc_result_output_port
   import adc_out_pkg::*;
(
   // system clock and reset
   input wire logic sys_clk_in,
   input wire logic reset_in,
   // bit clock oscillator, free running
   input wire logic link_clk_in,
   // conversion request and sampled value
   input wire logic convert_start_in,
   input wire logic [RESULT_BITS-1:0] conversion_value_in,
   // result pins, link domain
   output result_pins_type result_pins_out,
   // busy level, system domain
   output logic conv_busy_out
);

   ////////////////////////////////////////////////////////////////////////////
   // state and crossings
   sys_state_type sys_q;
   sys_state_type sys_d;
   link_state_type link_q;
   link_state_type link_d;
   logic start_pin_s;
   logic start_toggle_s;

   // convert start is an outside pin
   bit_sync start_pin_sync (
      .clk_in(sys_clk_in),
      .reset_in(reset_in),
      .level_in(convert_start_in),
      .level_out(start_pin_s)
   );

   // start event travels as a toggle into the bit-clock domain
   bit_sync start_event_sync (
      .clk_in(link_clk_in),
      .reset_in(reset_in),
      .level_in(sys_q.start_toggle),
      .level_out(start_toggle_s)
   );

   // status travels back as a level
   bit_sync busy_sync (
      .clk_in(sys_clk_in),
      .reset_in(reset_in),
      .level_in(link_q.pins.status),
      .level_out(conv_busy_out)
   );

   ////////////////////////////////////////////////////////////////////////////
   // system domain: catch the trailing edge of convert start
   always_comb
   begin
      sys_d = sys_q;
      sys_d.start_seen = start_pin_s;
      // a start during a conversion is ignored so the held value stays stable
      if (sys_q.start_seen && !start_pin_s && !conv_busy_out)
      begin
         sys_d.value = conversion_value_in;
         sys_d.start_toggle = ~sys_q.start_toggle;
      end
   end

   always_ff @(posedge sys_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         sys_q.start_seen <= 1'b0;
         sys_q.start_toggle <= 1'b0;
         sys_q.value <= VALUE_RESET;
      end
      else
      begin
         sys_q <= sys_d;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // bit index decided at a given step
   function automatic logic [3:0] bit_index(input logic [STEP_BITS-1:0] step);
      logic [STEP_BITS-1:0] idx;
      idx = STEP_BITS'(RESULT_BITS) - step;
      return idx[3:0];
   endfunction : bit_index

   ////////////////////////////////////////////////////////////////////////////
   // link domain: gated clock, successive decisions and pin updates
   // the held value is stable for two link edges before the toggle arrives
   always_comb
   begin
      logic [3:0] idx;
      logic decided;
      idx = 4'h0;
      decided = 1'b0;
      link_d = link_q;
      case (link_q.mode)
         LINK_IDLE:
         begin
            link_d.pins.clock = 1'b0;
            if (start_toggle_s != link_q.start_seen)
            begin
               link_d.start_seen = start_toggle_s;
               link_d.mode = LINK_RUN;
               link_d.step = FIRST_STEP;
               link_d.code = CODE_RESET;
               link_d.pins.status = 1'b1;
            end
         end
         LINK_RUN:
         begin
            if (!link_q.pins.clock)
            begin
               // rising edge of the clock output: pins move with it
               link_d.pins.clock = 1'b1;
               if (link_q.step == FIRST_STEP)
               begin
                  // t0: trial on the MSB, nothing decided yet
                  link_d.code[RESULT_BITS-1] = 1'b0;
                  link_d.pins.serial_n = ~INVALID_BIT;
               end
               else
               begin
                  idx = bit_index(link_q.step);
                  // complementary binary: a one in the value decides a zero
                  decided = ~sys_q.value[idx];
                  link_d.code[idx] = decided;
                  if (idx != 4'h0)
                  begin
                     link_d.code[idx-4'h1] = 1'b0;
                  end
                  link_d.pins.serial_n = ~decided;
               end
               link_d.pins.parallel_n = ~link_d.code;
               link_d.step = link_q.step + 5'h01;
            end
            else
            begin
               // falling edge: the receiver samples here
               link_d.pins.clock = 1'b0;
               if (link_q.step == CLOCK_EDGES)
               begin
                  // word settled a full link period before this fall
                  link_d.pins.status = 1'b0;
                  link_d.mode = LINK_IDLE;
               end
            end
         end
         default:
         begin
            link_d.mode = LINK_IDLE;
            link_d.pins.clock = 1'b0;
            link_d.pins.status = 1'b0;
         end
      endcase
   end

   // reset is taken straight here; release is safe since idle waits for a toggle
   always_ff @(posedge link_clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         link_q.mode <= LINK_IDLE;
         link_q.start_seen <= 1'b0;
         link_q.step <= FIRST_STEP;
         link_q.code <= CODE_RESET;
         link_q.pins.clock <= 1'b0;
         link_q.pins.status <= 1'b0;
         link_q.pins.serial_n <= ~INVALID_BIT;
         link_q.pins.parallel_n <= PINS_IDLE_N;
      end
      else
      begin
         link_q <= link_d;
      end
   end

   assign result_pins_out = link_q.pins;

endmodule : adc_result_output_port

`default_nettype wire

// [verilog/bit_sync.sv]
// two-flop level synchroniser
`timescale 1ns/1ns
`default_nettype none

module bit_sync
   import adc_out_pkg::*;
(
   // clock and reset
   input wire logic clk_in,
   input wire logic reset_in,
   // level
   input wire logic level_in,
   output logic level_out
);

   sync_state_type state_q;
   sync_state_type state_d;

   ////////////////////////////////////////////////////////////////////////////
   // meta is read by sync only
   always_comb
   begin
      state_d = state_q;
      state_d.meta = level_in;
      state_d.sync = state_q.meta;
   end

   always_ff @(posedge clk_in or posedge reset_in)
   begin
      if (reset_in)
      begin
         state_q <= '0;
      end
      else
      begin
         state_q <= state_d;
      end
   end

   assign level_out = state_q.sync;

endmodule : bit_sync

`default_nettype wire
